// ==== core/channel_timing_config.v ====
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`include "chan_timing_consts.vh"

module channel_timing_config #(
	parameter [`DEB_CNT_W-1:0] DEB_T1_CYC = `DEB_T1_CNT,
	parameter [`DEB_CNT_W-1:0] DEB_T2_CYC = `DEB_T2_CNT,
	parameter [`DEB_CNT_W-1:0] DEB_T3_CYC = `DEB_T3_CNT
) (
	input  wire               mclk,
	input  wire               reset,
	input  wire [`ADDR_W-1:0] addr,
	input  wire [`DATA_W-1:0] wdata,
	input  wire               wr_stb,
	input  wire               rd_stb,
	output reg  [`DATA_W-1:0] rdata_ff,
	input  wire               pg_cond,
	input  wire               sync_ref,
	output wire               chan_a_power_good,
	output wire               sw_tick_a,
	output wire               sw_tick_b,
	output wire               sw_tick_c,
	output reg                irq_ff
);

	// ****************************************************************
	// decode helpers
	// ****************************************************************
	function is_freq;
		input [`ADDR_W-1:0] a;
		begin
			is_freq = (a == `OFS_FREQ_A) || (a == `OFS_FREQ_B) || (a == `OFS_FREQ_C);
		end
	endfunction

	function [1:0] freq_idx;
		input [`ADDR_W-1:0] a;
		begin
			case (a)
				`OFS_FREQ_A: freq_idx = 2'h0;
				`OFS_FREQ_B: freq_idx = 2'h1;
				`OFS_FREQ_C: freq_idx = 2'h2;
				default:     freq_idx = 2'h0;
			endcase
		end
	endfunction

	// switching period in clock cycles for each frequency code
	function [`PER_W-1:0] code_period;
		input [5:0] c;
		begin
			case (c)
				6'h00: code_period = 16'h0400;
				6'h01: code_period = 16'h0380;
				6'h02: code_period = 16'h0340;
				6'h03: code_period = 16'h0300;
				6'h04: code_period = 16'h02c0;
				6'h05: code_period = 16'h0280;
				6'h06: code_period = 16'h0240;
				6'h07: code_period = 16'h0200;
				6'h08: code_period = 16'h01e0;
				6'h09: code_period = 16'h01c0;
				6'h0a: code_period = 16'h01a0;
				6'h0b: code_period = 16'h0180;
				6'h0c: code_period = 16'h0170;
				6'h0d: code_period = 16'h0160;
				6'h0e: code_period = 16'h0150;
				6'h0f: code_period = 16'h0140;
				6'h10: code_period = 16'h0130;
				6'h11: code_period = 16'h0120;
				6'h12: code_period = 16'h0110;
				6'h13: code_period = 16'h0100;
				6'h14: code_period = 16'h00f8;
				6'h15: code_period = 16'h00f0;
				6'h16: code_period = 16'h00e8;
				6'h17: code_period = 16'h00e0;
				6'h18: code_period = 16'h00d8;
				6'h19: code_period = 16'h00d0;
				6'h1a: code_period = 16'h00c8;
				6'h1b: code_period = 16'h00c0;
				6'h1c: code_period = 16'h00b8;
				6'h1d: code_period = 16'h00b0;
				6'h1e: code_period = 16'h00a8;
				6'h1f: code_period = 16'h00a0;
				6'h20: code_period = 16'h009c;
				6'h21: code_period = 16'h0098;
				6'h22: code_period = 16'h0094;
				6'h23: code_period = 16'h0090;
				6'h24: code_period = 16'h008c;
				6'h25: code_period = 16'h0088;
				6'h26: code_period = 16'h0084;
				6'h27: code_period = 16'h0080;
				6'h28: code_period = 16'h007e;
				6'h29: code_period = 16'h007c;
				6'h2a: code_period = 16'h007a;
				6'h2b: code_period = 16'h0078;
				6'h2c: code_period = 16'h0076;
				6'h2d: code_period = 16'h0074;
				6'h2e: code_period = 16'h0072;
				6'h2f: code_period = 16'h0070;
				6'h30: code_period = 16'h006e;
				6'h31: code_period = 16'h006c;
				6'h32: code_period = 16'h006a;
				6'h33: code_period = 16'h0068;
				6'h34: code_period = 16'h0066;
				6'h35: code_period = 16'h0064;
				6'h36: code_period = 16'h0062;
				6'h37: code_period = 16'h0060;
				6'h38: code_period = 16'h005e;
				6'h39: code_period = 16'h005c;
				6'h3a: code_period = 16'h005a;
				6'h3b: code_period = 16'h0058;
				6'h3c: code_period = 16'h0056;
				6'h3d: code_period = 16'h0054;
				6'h3e: code_period = 16'h0052;
				6'h3f: code_period = 16'h0050;
				default: code_period = 16'h0400;
			endcase
		end
	endfunction

	// ****************************************************************
	// registers
	// ****************************************************************
	reg  [`DATA_W-1:0]  pg_deb_ff;
	wire [`DATA_W-1:0]  freq_ff [0:`NUM_CHAN-1];
	reg  [`NUM_CHAN-1:0] sync_en_ff;
	reg  [`IRQ_W-1:0]   irq_status_ff;
	reg  [`IRQ_W-1:0]   irq_mask_ff;
	reg  [`DATA_W-1:0]  nxt_rdata;
	reg  [`IRQ_W-1:0]   nxt_irq_status;
	reg                 pg_prev_ff;
	reg  [`PER_W-1:0]   ref_cnt_ff;
	reg  [`PER_W-1:0]   ref_per_ff;
	wire [`NUM_CHAN-1:0] tick_ff;
	wire                pg_flag;
	wire                wr_freq;
	wire [`IRQ_W-1:0]   irq_event;
	wire                status_rd;

	assign wr_freq   = wr_stb && is_freq(addr);
	assign status_rd = rd_stb && (addr == `OFS_IRQ_STATUS);

	// ****************************************************************
	// register writes
	// ****************************************************************
	always @(posedge mclk) begin
		if (reset) begin
			pg_deb_ff <= `RST_PG_DEBOUNCE;
		end else if (wr_stb && (addr == `OFS_PG_DEBOUNCE)) begin
			pg_deb_ff <= wdata;
		end
	end

	always @(posedge mclk) begin
		if (reset) begin
			sync_en_ff <= `RST_SYNC_EN;
		end else if (wr_stb && (addr == `OFS_SYNC_EN)) begin
			sync_en_ff <= wdata[`NUM_CHAN-1:0];
		end
	end

	always @(posedge mclk) begin
		if (reset) begin
			irq_mask_ff <= `RST_IRQ_MASK;
		end else if (wr_stb && (addr == `OFS_IRQ_MASK)) begin
			irq_mask_ff <= wdata[`IRQ_W-1:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_CHAN; gi = gi + 1) begin : g_freq
			reg [`DATA_W-1:0] f_ff;

			// reserved multiples are stored as written
			always @(posedge mclk) begin
				if (reset) begin
					f_ff <= `RST_FREQ;
				end else if (wr_freq && (freq_idx(addr) == gi)) begin
					f_ff <= wdata;
				end
			end

			assign freq_ff[gi] = f_ff;
		end
	endgenerate

	// ****************************************************************
	// power-good debounce
	// ****************************************************************
	pg_debounce #(
		.T1_CYC (DEB_T1_CYC),
		.T2_CYC (DEB_T2_CYC),
		.T3_CYC (DEB_T3_CYC)
	) u_pg_debounce (
		.mclk    (mclk),
		.reset   (reset),
		.cond    (pg_cond),
		.on_sel  (pg_deb_ff[`PG_ON_HI:`PG_ON_LO]),
		.off_sel (pg_deb_ff[`PG_OFF_HI:`PG_OFF_LO]),
		.flag_ff (pg_flag)
	);

	assign chan_a_power_good = pg_flag;

	// ****************************************************************
	// synchronization reference period
	// ****************************************************************
	always @(posedge mclk) begin
		if (reset) begin
			ref_cnt_ff <= {`PER_W{1'b0}};
			ref_per_ff <= {`PER_W{1'b0}};
		end else if (sync_ref) begin
			ref_cnt_ff <= {`PER_W{1'b0}};
			ref_per_ff <= ref_cnt_ff + 16'h0001;
		end else if (ref_cnt_ff != {`PER_W{1'b1}}) begin
			ref_cnt_ff <= ref_cnt_ff + 16'h0001;
		end
	end

	// ****************************************************************
	// per-channel switching clocks
	// ****************************************************************
	generate
		for (gi = 0; gi < `NUM_CHAN; gi = gi + 1) begin : g_chan
			reg  [`PER_W-1:0] ph_ff;
			reg               t_ff;
			wire [`PER_W-1:0] ph_inc;
			wire [`PER_W-1:0] period;
			wire [`PER_W-1:0] half_ref;
			wire              dbl;

			assign ph_inc   = (ph_ff == {`PER_W{1'b1}}) ? ph_ff : ph_ff + 16'h0001;
			assign period   = code_period(freq_ff[gi][`CODE_HI:`CODE_LO]);
			assign half_ref = {1'b0, ref_per_ff[`PER_W-1:1]};
			// reserved multiple codes fall back to one times
			assign dbl      = (freq_ff[gi][`MULT_HI:`MULT_LO] == `MULT_X2);

			always @(posedge mclk) begin
				if (reset) begin
					ph_ff <= {`PER_W{1'b0}};
					t_ff  <= 1'b0;
				end else if (sync_en_ff[gi]) begin
					if (sync_ref) begin
						ph_ff <= {`PER_W{1'b0}};
						t_ff  <= 1'b1;
					end else if (dbl && (ph_inc == half_ref)) begin
						ph_ff <= ph_inc;
						t_ff  <= 1'b1;
					end else begin
						ph_ff <= ph_inc;
						t_ff  <= 1'b0;
					end
				end else if (ph_inc >= period) begin
					ph_ff <= {`PER_W{1'b0}};
					t_ff  <= 1'b1;
				end else begin
					ph_ff <= ph_inc;
					t_ff  <= 1'b0;
				end
			end

			assign tick_ff[gi] = t_ff;
		end
	endgenerate

	// ****************************************************************
	// switching clock outputs
	// ****************************************************************
	assign sw_tick_a = tick_ff[0];
	assign sw_tick_b = tick_ff[1];
	assign sw_tick_c = tick_ff[2];

	// ****************************************************************
	// interrupts
	// ****************************************************************
	assign irq_event[`IRQ_PG_SET]   = pg_flag && !pg_prev_ff;
	assign irq_event[`IRQ_PG_CLR]   = !pg_flag && pg_prev_ff;
	assign irq_event[`IRQ_MULT_RSV] = wr_freq && wdata[`MULT_HI];

	// a new event wins over the read that clears
	always @* begin
		nxt_irq_status = (status_rd ? {`IRQ_W{1'b0}} : irq_status_ff) | irq_event;
	end

	// flag edge detector, idle low like the flag itself after reset
	always @(posedge mclk) begin
		if (reset) begin
			pg_prev_ff <= 1'b0;
		end else begin
			pg_prev_ff <= pg_flag;
		end
	end

	always @(posedge mclk) begin
		if (reset) begin
			irq_status_ff <= {`IRQ_W{1'b0}};
			irq_ff        <= 1'b0;
		end else begin
			irq_status_ff <= nxt_irq_status;
			irq_ff        <= |(nxt_irq_status & irq_mask_ff);
		end
	end

	// ****************************************************************
	// register reads
	// ****************************************************************
	always @* begin
		nxt_rdata = {`DATA_W{1'b0}};
		if (is_freq(addr)) begin
			nxt_rdata = freq_ff[freq_idx(addr)];
		end else begin
			case (addr)
				`OFS_PG_DEBOUNCE: nxt_rdata = pg_deb_ff;
				`OFS_SYNC_EN:     nxt_rdata = {5'h00, sync_en_ff};
				`OFS_IRQ_STATUS:  nxt_rdata = {5'h00, irq_status_ff};
				`OFS_IRQ_MASK:    nxt_rdata = {5'h00, irq_mask_ff};
				`OFS_STATE:       nxt_rdata = {6'h00, pg_cond, pg_flag};
				default:          nxt_rdata = {`DATA_W{1'b0}};
			endcase
		end
	end

	// read data stand only in the cycle after the strobe
	always @(posedge mclk) begin
		if (reset) begin
			rdata_ff <= {`DATA_W{1'b0}};
		end else if (rd_stb) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= {`DATA_W{1'b0}};
		end
	end

endmodule

// ==== core/chan_timing_consts.vh ====
`ifndef CHAN_TIMING_CONSTS_VH
`define CHAN_TIMING_CONSTS_VH

// ****************************************************************
// bus geometry
// ****************************************************************
`define ADDR_W            16
`define DATA_W            8

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_PG_DEBOUNCE   16'hfe09
`define OFS_FREQ_A        16'hfe0a
`define OFS_FREQ_B        16'hfe0b
`define OFS_FREQ_C        16'hfe0c
`define OFS_SYNC_EN       16'hfe0e
`define OFS_IRQ_STATUS    16'hfe10
`define OFS_IRQ_MASK      16'hfe11
`define OFS_STATE         16'hfe12

// ****************************************************************
// field positions and codes
// ****************************************************************
`define PG_ON_HI          3
`define PG_ON_LO          2
`define PG_OFF_HI         1
`define PG_OFF_LO         0
`define MULT_HI           7
`define MULT_LO           6
`define CODE_HI           5
`define CODE_LO           0
`define MULT_X1           2'h0
`define MULT_X2           2'h1
`define IRQ_PG_SET        0
`define IRQ_PG_CLR        1
`define IRQ_MULT_RSV      2
`define IRQ_W             3
`define NUM_CHAN          3

// ****************************************************************
// reset values
// ****************************************************************
`define RST_PG_DEBOUNCE   8'h00
`define RST_FREQ          8'h00
`define RST_SYNC_EN       3'h0
`define RST_IRQ_MASK      3'h0

// ****************************************************************
// timing
// ****************************************************************
`define CLK_KHZ           50000
`define DEB_T1_MS         200
`define DEB_T2_MS         320
`define DEB_T3_MS         600
`define DEB_T1_CNT        25'd10000000
`define DEB_T2_CNT        25'd16000000
`define DEB_T3_CNT        25'd30000000
`define DEB_CNT_W         25
`define PER_W             16

`endif

// ==== core/pg_debounce.v ====
`timescale 1ns/1ns
`include "chan_timing_consts.vh"

module pg_debounce #(
	parameter [`DEB_CNT_W-1:0] T1_CYC = `DEB_T1_CNT,
	parameter [`DEB_CNT_W-1:0] T2_CYC = `DEB_T2_CNT,
	parameter [`DEB_CNT_W-1:0] T3_CYC = `DEB_T3_CNT
) (
	input  wire       mclk,
	input  wire       reset,
	input  wire       cond,
	input  wire [1:0] on_sel,
	input  wire [1:0] off_sel,
	output reg        flag_ff
);

	// ****************************************************************
	// delay selection
	// ****************************************************************
	function [`DEB_CNT_W-1:0] sel_limit;
		input [1:0] s;
		begin
			case (s)
				2'h0: sel_limit = {`DEB_CNT_W{1'b0}};
				2'h1: sel_limit = T1_CYC;
				2'h2: sel_limit = T2_CYC;
				2'h3: sel_limit = T3_CYC;
				default: sel_limit = {`DEB_CNT_W{1'b0}};
			endcase
		end
	endfunction

	reg  [`DEB_CNT_W-1:0] cnt_ff;
	wire [1:0]            sel;
	wire [`DEB_CNT_W-1:0] lim;
	wire [`DEB_CNT_W-1:0] cnt_inc;

	// the set direction uses the on time, the clear direction the off time
	assign sel     = flag_ff ? off_sel : on_sel;
	assign lim     = sel_limit(sel);
	assign cnt_inc = cnt_ff + {{(`DEB_CNT_W-1){1'b0}}, 1'b1};

	// ****************************************************************
	// debounce counter
	// ****************************************************************
	// condition must hold unbroken; any bounce restarts the wait
	always @(posedge mclk) begin
		if (reset) begin
			cnt_ff  <= {`DEB_CNT_W{1'b0}};
			flag_ff <= 1'b0;
		end else if (cond == flag_ff) begin
			cnt_ff <= {`DEB_CNT_W{1'b0}};
		end else if (cnt_inc >= lim) begin
			flag_ff <= cond;
			cnt_ff  <= {`DEB_CNT_W{1'b0}};
		end else begin
			cnt_ff <= cnt_inc;
		end
	end

endmodule

// ==== tb/channel_timing_config_asserts.sv ====
`timescale 1ns/1ns
`include "chan_timing_consts.vh"

module channel_timing_config_asserts #(
	parameter [`DEB_CNT_W-1:0] DEB_T1_CYC = 25'd20,
	parameter [`DEB_CNT_W-1:0] DEB_T2_CYC = 25'd32,
	parameter [`DEB_CNT_W-1:0] DEB_T3_CYC = 25'd60
) (
	input wire               mclk,
	input wire               reset,
	input wire [`ADDR_W-1:0] addr,
	input wire [`DATA_W-1:0] wdata,
	input wire               wr_stb,
	input wire               rd_stb,
	input wire [`DATA_W-1:0] rdata_ff,
	input wire               pg_cond,
	input wire               sync_ref,
	input wire               chan_a_power_good,
	input wire               sw_tick_a,
	input wire               sw_tick_b,
	input wire               sw_tick_c,
	input wire               irq_ff
);
	reg [7:0]  deb_ff;
	reg [2:0]  sync_en_ff;
	reg [31:0] cnt_ff;

	function automatic [31:0] deb_len(input [1:0] s);
		case (s)
			2'h0: deb_len = 32'h1;
			2'h1: deb_len = {7'h0, DEB_T1_CYC};
			2'h2: deb_len = {7'h0, DEB_T2_CYC};
			default: deb_len = {7'h0, DEB_T3_CYC};
		endcase
	endfunction

	// shadow fields and count of edges where condition and flag disagree
	always @(posedge mclk) begin
		if (reset) begin
			deb_ff     <= 8'h00;
			sync_en_ff <= 3'h0;
			cnt_ff     <= 32'h0;
		end else begin
			if (wr_stb && addr == `OFS_PG_DEBOUNCE)
				deb_ff <= wdata;
			if (wr_stb && addr == `OFS_SYNC_EN)
				sync_en_ff <= wdata[2:0];
			cnt_ff <= (pg_cond != chan_a_power_good) ? cnt_ff + 32'h1 : 32'h0;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_wr_gap_rd(a);
		(wr_stb && addr == a) ##1 !wr_stb ##1 (rd_stb && addr == a);
	endsequence
	property p_read_back(a);
		s_wr_gap_rd(a) |=> rdata_ff == $past(wdata, 3);
	endproperty

	chk_read_quiet: assert property (rdata_ff != 8'h00 |-> $past(rd_stb))
		else $error("read data outside its cycle");
	chk_back_deb: assert property (p_read_back(`OFS_PG_DEBOUNCE))
		else $error("debounce register readback wrong");
	chk_back_freq_a: assert property (p_read_back(`OFS_FREQ_A))
		else $error("channel a frequency readback wrong");
	chk_back_freq_c: assert property (p_read_back(`OFS_FREQ_C))
		else $error("channel c frequency readback wrong");
	chk_on_length: assert property ($rose(chan_a_power_good) && !$past(reset) |-> cnt_ff == deb_len(deb_ff[3:2]))
		else $error("flag set after wrong debounce length");
	chk_off_length: assert property ($fell(chan_a_power_good) && !$past(reset) |-> cnt_ff == deb_len(deb_ff[1:0]))
		else $error("flag cleared after wrong debounce length");
	chk_sync_tick_a: assert property (sync_en_ff[0] && sync_ref |=> sw_tick_a)
		else $error("channel a missed reference tick");
	chk_sync_tick_b: assert property (sync_en_ff[1] && sync_ref |=> sw_tick_b)
		else $error("channel b missed reference tick");
	chk_sync_tick_c: assert property (sync_en_ff[2] && sync_ref |=> sw_tick_c)
		else $error("channel c missed reference tick");
endmodule

// ==== tb/test_channel_timing_config.sv ====
`timescale 1ns/1ns
`include "chan_timing_consts.vh"

module test_channel_timing_config;
	reg         mclk, reset, wr_stb, rd_stb, pg_cond, sync_ref;
	reg  [15:0] addr;
	reg  [7:0]  wdata, rd_val;
	wire [7:0]  rdata_ff;
	wire        chan_a_power_good, sw_tick_a, sw_tick_b, sw_tick_c, irq_ff;
	wire [2:0]  ticks = {sw_tick_c, sw_tick_b, sw_tick_a};
	integer     failures = 0, compares = 0, i, n, ch, t0, e;
	integer     tally [0:2];
	integer     codes [0:3];
	integer     khz10 [0:3];
	logic [7:0] mdl [0:3];

	initial mclk = 1'b0;
	always #10 mclk = ~mclk;

	channel_timing_config #(.DEB_T1_CYC(20), .DEB_T2_CYC(32), .DEB_T3_CYC(60)) dut (
		.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata_ff(rdata_ff), .pg_cond(pg_cond), .sync_ref(sync_ref), .chan_a_power_good(chan_a_power_good),
		.sw_tick_a(sw_tick_a), .sw_tick_b(sw_tick_b), .sw_tick_c(sw_tick_c), .irq_ff(irq_ff));

	// ****************************************************************
	// tasks
	// ****************************************************************
	task check(input logic [15:0] seen, input logic [15:0] exp);
		compares = compares + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task final_report;
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task wr(input [15:0] a, input [7:0] d);
		wr_stb <= 1'b1;
		addr   <= a;
		wdata  <= d;
		@(posedge mclk);
		wr_stb <= 1'b0;
		@(posedge mclk);
	endtask

	task rd(input [15:0] a);
		rd_stb <= 1'b1;
		addr   <= a;
		@(posedge mclk);
		rd_stb <= 1'b0;
		@(negedge mclk);
		rd_val = rdata_ff;
		@(posedge mclk);
	endtask

	// drive the condition and count edges until the flag follows
	task settle(input logic lvl);
		pg_cond <= lvl;
		t0 = 0;
		do begin
			@(posedge mclk);
			t0 = t0 + 1;
			@(negedge mclk);
		end while (chan_a_power_good !== lvl && t0 < 100);
		@(posedge mclk);
	endtask

	task tick_gap(input integer c);
		t0 = 0;
		do begin
			@(posedge mclk);
			t0 = t0 + 1;
			@(negedge mclk);
		end while (ticks[c] !== 1'b1 && t0 < 3000);
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{reset, wr_stb, rd_stb, pg_cond, sync_ref} = 5'b10000;
		addr = 16'h0000;
		wdata = 8'h00;
		tally[0] = 0;
		tally[1] = 0;
		tally[2] = 0;
		codes[0] = 0;
		codes[1] = 1;
		codes[2] = 24;
		codes[3] = 63;
		khz10[0] = 488;
		khz10[1] = 558;
		khz10[2] = 2315;
		khz10[3] = 6250;
		void'($urandom(77388));
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		for (i = 0; i < 4; i++) begin
			rd(16'(16'hfe09 + i));
			check(rd_val, 8'h00);
			mdl[i] = 8'($urandom);
			if (i > 0)
				mdl[i][7] = 1'b0;
			wr(16'(16'hfe09 + i), mdl[i]);
			rd(16'(16'hfe09 + i));
			check(rd_val, mdl[i]);
		end
		for (i = 0; i < 4; i++) begin
			rd(16'(16'hfe09 + i));
			check(rd_val, mdl[i]);
		end
		wr(16'hfe0d, 8'h5a);
		rd(16'hfe0d);
		check(rd_val, 8'h00);
		wr(`OFS_FREQ_C, 8'hc5);
		rd(`OFS_FREQ_C);
		check(rd_val, 8'hc5);
		rd(`OFS_IRQ_STATUS);
		check(rd_val, 8'h04);
		for (i = 0; i < 4; i++) begin
			wr(`OFS_PG_DEBOUNCE, 8'(i * 5));
			n = (i == 0) ? 1 : (i == 1) ? 20 : (i == 2) ? 32 : 60;
			if (n > 1) begin
				pg_cond <= 1'b1;
				repeat (n - 1) @(posedge mclk);
				pg_cond <= 1'b0;
				rd(`OFS_STATE);
				check(rd_val, 8'h00);
			end
			settle(1'b1);
			check(16'(t0), 16'(n));
			settle(1'b0);
			check(16'(t0), 16'(n));
		end
		rd(`OFS_IRQ_STATUS);
		check(rd_val, 8'h03);
		check(irq_ff, 1'b0);
		wr(`OFS_IRQ_MASK, 8'h01);
		settle(1'b1);
		rd(`OFS_IRQ_MASK);
		check(irq_ff, 1'b1);
		rd(`OFS_IRQ_STATUS);
		check(rd_val, 8'h01);
		settle(1'b0);
		rd(`OFS_IRQ_MASK);
		check(irq_ff, 1'b0);
		// free-running period per code, within one cycle of the table
		for (i = 0; i < 6; i++) begin
			ch = i % 3;
			wr(16'(`OFS_FREQ_A + ch), 8'(codes[i % 4]));
			tick_gap(ch);
			tick_gap(ch);
			e = (1000000 / khz10[i % 4] + 1) / 2;
			check(16'(t0 >= e - 1 && t0 <= e + 1), 16'h0001);
			@(posedge mclk);
		end
		wr(`OFS_FREQ_A, 8'h00);
		wr(`OFS_FREQ_B, 8'h40);
		wr(`OFS_FREQ_C, 8'hc0);
		wr(`OFS_SYNC_EN, 8'h07);
		for (i = 0; i < 1000; i++) begin
			sync_ref <= (i % 200 == 0);
			@(negedge mclk);
			for (ch = 0; ch < 3; ch++)
				if (i >= 400 && ticks[ch] === 1'b1)
					tally[ch] = tally[ch] + 1;
			@(posedge mclk);
		end
		check(16'(tally[0]), 16'h0003);
		check(16'(tally[1]), 16'h0006);
		check(16'(tally[2]), 16'h0003);
		final_report;
	end

	initial begin
		repeat (60000) @(posedge mclk);
		failures = failures + 1;
		final_report;
	end
endmodule

bind channel_timing_config channel_timing_config_asserts #(
	.DEB_T1_CYC(DEB_T1_CYC), .DEB_T2_CYC(DEB_T2_CYC), .DEB_T3_CYC(DEB_T3_CYC)
) chk (
	.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
	.rdata_ff(rdata_ff), .pg_cond(pg_cond), .sync_ref(sync_ref), .chan_a_power_good(chan_a_power_good),
	.sw_tick_a(sw_tick_a), .sw_tick_b(sw_tick_b), .sw_tick_c(sw_tick_c), .irq_ff(irq_ff)
);
